/* File: design/timer8_pkg.sv */
package timer8_pkg;
    // register offsets
    localparam logic [2:0] ADDR_CTRL_A = 3'h0;
    localparam logic [2:0] ADDR_CTRL_B = 3'h1;
    localparam logic [2:0] ADDR_COUNT  = 3'h2;
    localparam logic [2:0] ADDR_CMP_A  = 3'h3;
    localparam logic [2:0] ADDR_CMP_B  = 3'h4;
    localparam logic [2:0] ADDR_FLAGS  = 3'h5;
    // field positions
    localparam int CA_ACT_A_LSB = 6;
    localparam int CA_ACT_B_LSB = 4;
    localparam int CA_MODE_LSB  = 0;
    localparam int CB_FORCE_A   = 7;
    localparam int CB_FORCE_B   = 6;
    localparam int CB_MODE_HI   = 3;
    localparam int FL_OVF       = 0;
    localparam int FL_CMP_A     = 1;
    localparam int FL_CMP_B     = 2;
    // channel index
    localparam int CH_A = 0;
    localparam int CH_B = 1;
    // waveform modes
    localparam logic [2:0] MODE_NORMAL  = 3'h0;
    localparam logic [2:0] MODE_CLEAR   = 3'h2;
    localparam logic [2:0] MODE_FAST_FF = 3'h3;
    localparam logic [2:0] MODE_FAST_A  = 3'h7;
    // compare output actions
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;
    // values
    localparam logic [7:0] COUNT_MAX    = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_ONE    = 8'h01;
    localparam logic [7:0] BYTE_RESET   = 8'h00;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic [1:0] port_value;
        logic [1:0] direction;
    } pin_ctrl_t;
endpackage

/* File: design/timer8_waveform_output.sv */
module timer8_waveform_output
    import timer8_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    // timer clock enable from prescaler
    input  wire logic                  timer_tick,
    // register port
    input  wire timer8_pkg::reg_req_t  bus,
    output logic [7:0]                 rdata,
    // interrupt acknowledge per flag
    input  wire logic [2:0]            flag_ack,
    output logic [2:0]                 flags,
    // port pin side
    input  wire timer8_pkg::pin_ctrl_t pins,
    output logic [1:0]                 pin_out,
    output logic [1:0]                 pin_oe
);
    import timer8_pkg::*;

    typedef struct packed {
        logic [7:0]      cnt;
        logic [1:0][7:0] ocr;
        logic [1:0][7:0] ocr_buf;
        logic [1:0][1:0] act;
        logic [2:0]      mode;
        logic [2:0]      flags;
        logic [1:0]      oc;
        logic            block;
        logic [7:0]      rdata;
        logic [1:0]      pin_out;
        logic [1:0]      pin_oe;
    } state_t;

    state_t q;
    state_t d;

    logic       tick_en;
    logic       is_pwm;
    logic       non_pwm;
    logic [7:0] top;
    logic [1:0] match;
    logic       at_top;
    logic       cnt_write;
    logic       ctrl_b_write;

    // action on a compare match; toggle only where permitted
    function automatic logic oc_on_match(logic oc, logic [1:0] act, logic tgl_ok);
        logic r;
        r = oc;
        unique case (act)
            ACT_TOGGLE: r = tgl_ok ? ~oc : oc;
            ACT_CLEAR:  r = 1'b0;
            ACT_SET:    r = 1'b1;
            ACT_NONE:   r = oc;
        endcase
        return r;
    endfunction

    // fast PWM polarity restore when the counter leaves top
    function automatic logic oc_at_bottom(logic oc, logic [1:0] act);
        logic r;
        r = oc;
        if (act == ACT_CLEAR) begin
            r = 1'b1;
        end else if (act == ACT_SET) begin
            r = 1'b0;
        end
        return r;
    endfunction

    assign tick_en      = clk_en && timer_tick;
    assign is_pwm       = (q.mode == MODE_FAST_FF) || (q.mode == MODE_FAST_A);
    assign non_pwm      = (q.mode == MODE_NORMAL) || (q.mode == MODE_CLEAR);
    assign top          = (q.mode == MODE_FAST_FF) ? COUNT_MAX : q.ocr[CH_A];
    assign at_top       = is_pwm && (q.cnt == top);
    assign cnt_write    = clk_en && bus.wr && (bus.addr == ADDR_COUNT);
    assign ctrl_b_write = clk_en && bus.wr && (bus.addr == ADDR_CTRL_B);
    // a counter write blocks matches through the next timer tick
    assign match[CH_A]  = (q.cnt == q.ocr[CH_A]) && !q.block;
    assign match[CH_B]  = (q.cnt == q.ocr[CH_B]) && !q.block;

    always_comb begin
        logic [2:0] fl_set;
        logic [2:0] fl_clr;
        fl_set = 3'h0;
        fl_clr = 3'h0;
        d = q;
        // rdata holds while the enable is low, like every other register
        if (clk_en) begin
            d.rdata = BYTE_RESET;
            if (timer_tick) begin
                d.block = 1'b0;
                // sequencing reads only the mode field, never the actions
                unique case (q.mode)
                    MODE_NORMAL: begin
                        d.cnt = 8'(q.cnt + COUNT_ONE);
                        fl_set[FL_OVF] = (q.cnt == COUNT_MAX);
                    end
                    MODE_CLEAR: begin
                        // a top below the count is passed and met after wrap
                        d.cnt = match[CH_A] ? COUNT_BOTTOM : 8'(q.cnt + COUNT_ONE);
                        fl_set[FL_OVF] = (q.cnt == COUNT_MAX);
                    end
                    MODE_FAST_FF, MODE_FAST_A: begin
                        if (at_top) begin
                            d.cnt = COUNT_BOTTOM;
                            fl_set[FL_OVF] = 1'b1;
                            d.ocr = q.ocr_buf;
                        end else begin
                            d.cnt = 8'(q.cnt + COUNT_ONE);
                        end
                    end
                    default: begin
                        d.cnt = q.cnt;
                    end
                endcase
                if (non_pwm || is_pwm) begin
                    fl_set[FL_CMP_A] = match[CH_A];
                    fl_set[FL_CMP_B] = match[CH_B];
                end
                if (non_pwm) begin
                    for (int i = 0; i < 2; i++) begin
                        if (match[i]) begin
                            d.oc[i] = oc_on_match(q.oc[i], q.act[i], 1'b1);
                        end
                    end
                end else if (is_pwm) begin
                    if (match[CH_A]) begin
                        d.oc[CH_A] = oc_on_match(q.oc[CH_A], q.act[CH_A], q.mode[2]);
                    end
                    if (match[CH_B]) begin
                        d.oc[CH_B] = oc_on_match(q.oc[CH_B], q.act[CH_B], 1'b0);
                    end
                    // bottom wins over a match at top, so max compare stays constant
                    if (at_top) begin
                        for (int i = 0; i < 2; i++) begin
                            d.oc[i] = oc_at_bottom(d.oc[i], q.act[i]);
                        end
                    end
                end
            end
            if (bus.wr) begin
                unique case (bus.addr)
                    ADDR_CTRL_A: begin
                        d.act[CH_A] = bus.wdata[CA_ACT_A_LSB +: 2];
                        d.act[CH_B] = bus.wdata[CA_ACT_B_LSB +: 2];
                        d.mode[1:0] = bus.wdata[CA_MODE_LSB +: 2];
                    end
                    ADDR_CTRL_B: begin
                        d.mode[2] = bus.wdata[CB_MODE_HI];
                    end
                    ADDR_COUNT: begin
                        d.cnt   = bus.wdata;
                        d.block = 1'b1;
                    end
                    ADDR_CMP_A: begin
                        d.ocr_buf[CH_A] = bus.wdata;
                        if (!is_pwm) begin
                            d.ocr[CH_A] = bus.wdata;
                        end
                    end
                    ADDR_CMP_B: begin
                        d.ocr_buf[CH_B] = bus.wdata;
                        if (!is_pwm) begin
                            d.ocr[CH_B] = bus.wdata;
                        end
                    end
                    ADDR_FLAGS: begin
                        fl_clr = bus.wdata[2:0];
                    end
                    default: begin
                        d.cnt = d.cnt;
                    end
                endcase
            end
            // force acts on the output only; no flag, no counter change
            if (ctrl_b_write && non_pwm) begin
                if (bus.wdata[CB_FORCE_A]) begin
                    d.oc[CH_A] = oc_on_match(d.oc[CH_A], q.act[CH_A], 1'b1);
                end
                if (bus.wdata[CB_FORCE_B]) begin
                    d.oc[CH_B] = oc_on_match(d.oc[CH_B], q.act[CH_B], 1'b1);
                end
            end
            if (bus.rd) begin
                unique case (bus.addr)
                    ADDR_CTRL_A: begin
                        d.rdata[CA_ACT_A_LSB +: 2] = q.act[CH_A];
                        d.rdata[CA_ACT_B_LSB +: 2] = q.act[CH_B];
                        d.rdata[CA_MODE_LSB +: 2]  = q.mode[1:0];
                    end
                    ADDR_CTRL_B: d.rdata[CB_MODE_HI] = q.mode[2];
                    ADDR_COUNT:  d.rdata = q.cnt;
                    ADDR_CMP_A:  d.rdata = q.ocr_buf[CH_A];
                    ADDR_CMP_B:  d.rdata = q.ocr_buf[CH_B];
                    ADDR_FLAGS:  d.rdata[2:0] = q.flags;
                    default:     d.rdata = BYTE_RESET;
                endcase
            end
            fl_clr = fl_clr | flag_ack;
            // a flag raised in the clearing cycle survives
            d.flags = (q.flags & ~fl_clr) | fl_set;
            // override selection depends on the action only, in every mode
            for (int i = 0; i < 2; i++) begin
                d.pin_out[i] = (d.act[i] != ACT_NONE) ? d.oc[i] : pins.port_value[i];
            end
            // direction stays with the port; software must set it to drive
            d.pin_oe = pins.direction;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rdata   = q.rdata;
    assign flags   = q.flags;
    assign pin_out = q.pin_out;
    assign pin_oe  = q.pin_oe;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic act_a_write;
    assign act_a_write = clk_en && bus.wr && (bus.addr == ADDR_CTRL_A);

    sequence pwm_top_s;
        tick_en && at_top && !cnt_write;
    endsequence

    sequence bottom_ovf_s;
        (q.cnt == COUNT_BOTTOM) && q.flags[FL_OVF];
    endsequence

    reset_clears_oc_a: assert property (disable iff (1'b0) reset |=> q.oc == 2'h0)
        else $error("output state not cleared by reset");

    pin_override_a: assert property (
        clk_en && q.act[CH_A] != ACT_NONE && !act_a_write |=> pin_out[CH_A] == q.oc[CH_A])
        else $error("channel A pin not overridden");

    port_passthru_a: assert property (
        clk_en && q.act[CH_B] == ACT_NONE && !act_a_write
        |=> pin_out[CH_B] == $past(pins.port_value[CH_B]))
        else $error("channel B pin lost port value");

    direction_follow_a: assert property (
        clk_en |=> pin_oe == $past(pins.direction))
        else $error("pin direction not taken from port");

    idle_action_a: assert property (
        clk_en && q.act[CH_B] == ACT_NONE |=> $stable(q.oc[CH_B]))
        else $error("idle action changed output state");

    action_defer_a: assert property (
        act_a_write && !tick_en && !ctrl_b_write |=> $stable(q.oc))
        else $error("new action changed output before a match");

    normal_count_a: assert property (
        tick_en && q.mode == MODE_NORMAL && !cnt_write
        |=> q.cnt == 8'($past(q.cnt) + COUNT_ONE))
        else $error("normal mode count wrong");

    normal_ovf_a: assert property (
        tick_en && q.mode == MODE_NORMAL && q.cnt == COUNT_MAX && !cnt_write
        |=> q.flags[FL_OVF] && q.cnt == COUNT_BOTTOM)
        else $error("overflow not set at wrap");

    match_clear_a: assert property (
        tick_en && q.mode == MODE_CLEAR && match[CH_A] && !cnt_write
        |=> q.cnt == COUNT_BOTTOM && q.flags[FL_CMP_A])
        else $error("clear on match failed");

    late_top_a: assert property (
        tick_en && q.mode == MODE_CLEAR && !match[CH_A] && !cnt_write
        |=> q.cnt == 8'($past(q.cnt) + COUNT_ONE))
        else $error("clear on match skipped a count");

    match_toggle_a: assert property (
        tick_en && q.mode == MODE_CLEAR && match[CH_A] && q.act[CH_A] == ACT_TOGGLE
        && !ctrl_b_write |=> q.oc[CH_A] != $past(q.oc[CH_A]))
        else $error("clear on match did not toggle channel A");

    max_wrap_ovf_a: assert property (
        tick_en && q.mode == MODE_CLEAR && q.cnt == COUNT_MAX |=> q.flags[FL_OVF])
        else $error("overflow not set leaving max");

    pwm_wrap_a: assert property (pwm_top_s |=> bottom_ovf_s)
        else $error("fast PWM did not restart after top");

    pwm_climb_a: assert property (
        tick_en && is_pwm && !at_top && !cnt_write
        |=> q.cnt == 8'($past(q.cnt) + COUNT_ONE))
        else $error("fast PWM did not count up below top");

    pwm_polarity_a: assert property (
        pwm_top_s ##0 (q.act[CH_A] == ACT_CLEAR) |=> q.oc[CH_A])
        else $error("non-inverting output not set at bottom");

    pwm_inverse_a: assert property (
        pwm_top_s ##0 (q.act[CH_B] == ACT_SET) |=> !q.oc[CH_B])
        else $error("inverting output not cleared at bottom");

    pwm_notoggle_a: assert property (
        tick_en && q.mode == MODE_FAST_FF && q.act[CH_A] == ACT_TOGGLE
        |=> $stable(q.oc[CH_A]))
        else $error("toggle active without mode high bit");

    buffer_load_a: assert property (
        pwm_top_s |=> q.ocr == $past(q.ocr_buf))
        else $error("compare buffer not loaded at top");

    buffered_cmp_a: assert property (
        is_pwm && clk_en && bus.wr && bus.addr == ADDR_CMP_A && !tick_en
        |=> $stable(q.ocr[CH_A]))
        else $error("PWM compare write not buffered");

    direct_cmp_a: assert property (
        non_pwm && clk_en && bus.wr && bus.addr == ADDR_CMP_A
        |=> q.ocr[CH_A] == $past(bus.wdata))
        else $error("compare write not direct outside PWM");

    force_noflag_a: assert property (
        ctrl_b_write && bus.wdata[CB_FORCE_A] && !tick_en && !q.flags[FL_CMP_A]
        |=> !q.flags[FL_CMP_A])
        else $error("force strobe set compare flag");

    force_count_a: assert property (
        ctrl_b_write && non_pwm && bus.wdata[CB_FORCE_A] && !tick_en
        |=> $stable(q.cnt))
        else $error("force strobe moved the counter");

    flag_clear_a: assert property (
        clk_en && bus.wr && bus.addr == ADDR_FLAGS && bus.wdata[FL_OVF] && !tick_en
        |=> !q.flags[FL_OVF])
        else $error("write one did not clear overflow flag");

    illegal_hold_a: assert property (
        tick_en && !is_pwm && !non_pwm && !cnt_write |=> $stable(q.cnt) [*1])
        else $error("counter moved in unsupported mode");

    illegal_noflag_a: assert property (
        tick_en && !is_pwm && !non_pwm && q.flags == 3'h0
        |=> q.flags == 3'h0)
        else $error("flag set in unsupported mode");

endmodule // timer8_waveform_output

/* File: bench/port_pin_model.sv */
module port_pin_model
    import timer8_pkg::*;
(
    // software side port settings
    input  wire logic [1:0]       dir_cfg,
    input  wire logic [1:0]       val_cfg,
    // timer block side
    output timer8_pkg::pin_ctrl_t pins,
    input  wire logic [1:0]       pin_out,
    input  wire logic [1:0]       pin_oe,
    // pad levels
    output logic [1:0]            pad
);
    timeunit 1ns;
    timeprecision 100ps;

    // the override never touches direction, that stays with the port bits
    assign pins.direction  = dir_cfg;
    assign pins.port_value = val_cfg;

    // an undriven pad has no keeper: it shows the inverse of the drive, so a
    // released pin never looks like the output state
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pad[i] = pin_oe[i] ? pin_out[i] : ~pin_out[i];
        end
    end
endmodule // port_pin_model

/* File: bench/timer8_waveform_output_tb_top.sv */
module timer8_waveform_output_tb_top;
    import timer8_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic                  clk = 1'b0;
    logic                  reset = 1'b1;
    logic                  clk_en = 1'b1;
    logic                  timer_tick = 1'b0;
    timer8_pkg::reg_req_t  bus = '0;
    logic [7:0]            rdata;
    logic [2:0]            flag_ack = 3'h0;
    logic [2:0]            flags;
    timer8_pkg::pin_ctrl_t pins;
    logic [1:0]            pin_out;
    logic [1:0]            pin_oe;
    logic [1:0]            dir_cfg = 2'h1;
    logic [1:0]            val_cfg = 2'h2;
    logic [1:0]            pad;
    int                    n_fail = 0;
    int                    check_count = 0;
    int                    cycles = 0;

    always #25 clk = ~clk;

    timer8_waveform_output i_timer8_waveform_output (
        .clk(clk), .reset(reset), .clk_en(clk_en), .timer_tick(timer_tick),
        .bus(bus), .rdata(rdata), .flag_ack(flag_ack), .flags(flags),
        .pins(pins), .pin_out(pin_out), .pin_oe(pin_oe)
    );

    port_pin_model i_port_pin_model (
        .dir_cfg(dir_cfg), .val_cfg(val_cfg), .pins(pins),
        .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad)
    );

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // the whole run is well under a thousand ticks plus bus cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail = n_fail + 1;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // every bus, tick and ack task starts just after an edge and ends 1 ns after one
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
        #1;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        chk(what, rdata, exp);
    endtask

    task automatic run(input int n);
        timer_tick <= 1'b1;
        repeat (n) @(posedge clk);
        timer_tick <= 1'b0;
        #1;
    endtask

    task automatic ack_all();
        flag_ack <= 3'h7;
        @(posedge clk);
        flag_ack <= 3'h0;
        #1;
    endtask

    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, n_fail);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk("pin_out after reset", {6'h00, pin_out}, 8'h02);
        chk("pin_oe", {6'h00, pin_oe}, 8'h01);
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], 8'h00, "register after reset");
        end
        done("reset");

        wr(ADDR_COUNT, 8'hFE);
        run(2);
        chk("flags after wrap", {5'h00, flags}, 8'h01);
        rd(ADDR_COUNT, 8'h00, "count after wrap");
        wr(ADDR_FLAGS, 8'h01);
        rd(ADDR_FLAGS, 8'h00, "flags after write one");
        done("normal");

        wr(ADDR_CMP_A, 8'h03);
        wr(ADDR_CTRL_A, 8'h42);
        run(4);
        chk("flags at top", {5'h00, flags}, 8'h06);
        chk("pin_out toggled", {6'h00, pin_out}, 8'h03);
        chk("pad levels", {6'h00, pad}, 8'h01);
        rd(ADDR_COUNT, 8'h00, "count cleared at top");
        run(4);
        chk("pin_out toggled back", {6'h00, pin_out}, 8'h02);
        ack_all();
        wr(ADDR_COUNT, 8'h05);
        run(251);
        chk("flags after late top", {5'h00, flags}, 8'h01);
        chk("pin_out no match", {6'h00, pin_out}, 8'h02);
        run(4);
        chk("pin_out after wrap match", {6'h00, pin_out}, 8'h03);
        done("clear on match");

        ack_all();
        wr(ADDR_CTRL_A, 8'h80);
        chk("action waits for match", {6'h00, pin_out}, 8'h03);
        wr(ADDR_CTRL_B, 8'h80);
        chk("pin_out forced", {6'h00, pin_out}, 8'h02);
        chk("force sets no flag", {5'h00, flags}, 8'h00);
        rd(ADDR_COUNT, 8'h00, "force keeps count");
        done("force");

        wr(ADDR_CMP_A, 8'h02);
        wr(ADDR_CTRL_A, 8'hA3);
        wr(ADDR_CTRL_B, 8'h08);
        chk("channel b overridden", {6'h00, pin_out}, 8'h00);
        run(3);
        chk("fast pwm outputs at bottom", {6'h00, pin_out}, 8'h03);
        chk("fast pwm flags", {5'h00, flags}, 8'h07);
        rd(ADDR_COUNT, 8'h00, "cleared after top");
        run(1);
        chk("channel b cleared on match", {6'h00, pin_out}, 8'h01);
        ack_all();
        wr(ADDR_CMP_B, 8'h01);
        rd(ADDR_CMP_B, 8'h01, "compare b buffer");
        run(1);
        chk("buffered compare no match", {5'h00, flags}, 8'h00);
        run(2);
        chk("new compare after top", {6'h00, pin_out}, 8'h03);
        run(1);
        chk("match on new compare", {6'h00, pin_out}, 8'h01);
        rd(ADDR_CMP_A, 8'h02, "compare a");
        done("fast pwm");

        ack_all();
        wr(ADDR_CTRL_A, 8'h73);
        run(1);
        chk("toggle at top, inverse at bottom", {6'h00, pin_out}, 8'h00);
        run(2);
        chk("inverse set on match", {6'h00, pin_out}, 8'h02);
        wr(ADDR_CTRL_B, 8'h00);
        clk_en <= 1'b0;
        run(2);
        wr(ADDR_COUNT, 8'h55);
        clk_en <= 1'b1;
        rd(ADDR_COUNT, 8'h02, "count frozen while disabled");
        run(1);
        chk("no toggle in mode 3", {6'h00, pin_out}, 8'h02);
        wr(ADDR_CTRL_A, 8'h01);
        ack_all();
        run(2);
        chk("unsupported mode sets no flag", {5'h00, flags}, 8'h00);
        rd(ADDR_COUNT, 8'h03, "unsupported mode holds count");
        done("toggle and hold");

        give_verdict();
    end
endmodule // timer8_waveform_output_tb_top
